// ==== design/hwio_top.sv ====
// host wait output, reset handling and two interrupt outputs
//
// Behaviour
// - wait goes inactive when transfer completes
// - wait released to high impedance afterwards
// - wait polarity follows strap-selected host type
// - reset returns all registers to defaults
// - reset forces every output inactive except waitrequest, which is held high
// - primary irq forwarded only when bit enabled
// - primary irq carries all internal requests
// - control register sets drive and polarity
// - secondary irq also carries all requests
// - secondary irq may be dedicated single source
`timescale 1ns/10ps
module hwio_top #(
    parameter int NUM_SRC = hwio_pkg::HWIO_NUM_SRC
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [7:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic XFER_START_I,
    input wire logic [4:0] HOST_SELECT_STRAPS_I,
    input wire logic HOST_BUS_CLOCK_I,
    input wire logic [NUM_SRC-1:0] IRQ_SRC_I,
    output logic WAIT_PIN_O,
    output logic WAIT_PIN_OE_O,
    output logic XFER_DONE_O,
    output logic BUS_CLOCK_SEEN_O,
    output logic PRIMARY_IRQ_OUT_O,
    output logic PRIMARY_IRQ_OUT_OE_O,
    output logic SECONDARY_IRQ_OUT_O,
    output logic SECONDARY_IRQ_OUT_OE_O,
    output logic IRQ_O
);
    import hwio_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} hwio_wait_state_type;

    typedef struct packed {
        hwio_wait_state_type wst;
        logic [7:0] cnt;
        logic [7:0] wait_len;
        logic [15:0] ctl;
        logic [4:0] route;
        logic [HWIO_EV_W-1:0] status;
        logic [HWIO_EV_W-1:0] ien;
        logic [4:0] straps;
        logic strap_taken;
        logic any_irq_q;
        logic clk_q;
        logic clk_seen;
        logic wait_pin;
        logic wait_oe;
        logic done;
        logic irq;
        logic ack;
        logic [31:0] rdata;
    } hwio_state_type;

    hwio_state_type st;
    hwio_state_type next_st;
    logic start_s;
    logic host_bus_clock_s;
    logic [NUM_SRC-1:0] src_s;
    logic wait_high;
    logic any_irq;
    logic sec_req;
    logic bus_acc;
    logic [4:0] straps_s;
    logic strap_ok_s;

    // pins from outside the clock domain pass two flip-flops first
    hwio_sync #(.WIDTH(NUM_SRC + 2)) u_sync (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .d_i({IRQ_SRC_I, HOST_BUS_CLOCK_I, XFER_START_I}),
        .q_o({src_s, host_bus_clock_s, start_s})
    );

    // straps get their own stages; the marker bit arrives together with the first settled code
    hwio_sync #(.WIDTH(6)) u_strap_sync (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .d_i({1'b1, HOST_SELECT_STRAPS_I}),
        .q_o({strap_ok_s, straps_s})
    );

    // decodes the waiting polarity from the latched strap code
    function automatic logic wait_is_high(input logic [4:0] code);
        return code == HWIO_STRAP_WAIT_HIGH;
    endfunction

    assign wait_high = wait_is_high(st.straps);
    assign any_irq = |src_s;
    // dedicated mode picks one source, otherwise all are combined
    assign sec_req = st.route[HWIO_ROUTE_DED] ? src_s[st.route[3:0]] : any_irq;
    assign bus_acc = (AVS_READ_I || AVS_WRITE_I) && !st.ack;

    // next-state logic for wait sequencer, registers and bus
    always_comb
    begin
        next_st = st;
        next_st.ack = 1'b0;
        next_st.done = 1'b0;
        next_st.any_irq_q = any_irq;
        next_st.clk_q = host_bus_clock_s;
        // straps are caught once, as soon as their synchronised copy is valid
        if (!st.strap_taken && strap_ok_s)
        begin
            next_st.straps = straps_s;
            next_st.strap_taken = 1'b1;
        end
        // host bus clock activity indicator; host owns this clock
        if (host_bus_clock_s != st.clk_q)
            next_st.clk_seen = 1'b1;
        unique case (st.wst)
            ST_IDLE:
            begin
                next_st.wait_oe = 1'b0;
                if (start_s && st.strap_taken)
                begin
                    next_st.wst = ST_WAIT;
                    next_st.cnt = st.wait_len;
                    next_st.wait_oe = 1'b1;
                    next_st.wait_pin = wait_high;
                end
            end
            ST_WAIT:
            begin
                if (st.cnt <= 8'h01)
                begin
                    next_st.wst = ST_DONE;
                    next_st.cnt = 8'(HWIO_RELEASE_CYC);
                    next_st.wait_pin = !wait_high;
                    next_st.done = 1'b1;
                end
                else
                    next_st.cnt = st.cnt - 8'h01;
            end
            ST_DONE:
            begin
                // inactive level held before floating avoids a glitch on the pull-up
                if (st.cnt <= 8'h01)
                begin
                    next_st.wst = ST_IDLE;
                    next_st.wait_oe = 1'b0;
                end
                else
                    next_st.cnt = st.cnt - 8'h01;
            end
        endcase
        // sticky events; set wins over a clear in the same cycle
        if (AVS_WRITE_I && bus_acc && AVS_ADDRESS_I == HWIO_OFS_IRQ_CLEAR)
            next_st.status = st.status & ~AVS_WRITEDATA_I[HWIO_EV_W-1:0];
        if (st.done)
            next_st.status[HWIO_EV_XFER_DONE] = 1'b1;
        if (any_irq && !st.any_irq_q)
            next_st.status[HWIO_EV_IRQ_EDGE] = 1'b1;
        // register writes
        if (AVS_WRITE_I && bus_acc)
        begin
            unique case (AVS_ADDRESS_I)
                HWIO_OFS_IRQ_OUT_CTRL: next_st.ctl = AVS_WRITEDATA_I[15:0];
                HWIO_OFS_IRQ_ROUTE: next_st.route = AVS_WRITEDATA_I[4:0];
                HWIO_OFS_IRQ_ENABLE: next_st.ien = AVS_WRITEDATA_I[HWIO_EV_W-1:0];
                HWIO_OFS_XFER_CTRL: next_st.wait_len = AVS_WRITEDATA_I[7:0];
                default: ;
            endcase
        end
        // reads; unmapped offsets read zero
        next_st.rdata = '0;
        if (AVS_READ_I && bus_acc)
        begin
            unique case (AVS_ADDRESS_I)
                HWIO_OFS_IRQ_OUT_CTRL: next_st.rdata = {16'h0000, st.ctl};
                HWIO_OFS_IRQ_ROUTE: next_st.rdata = {27'h0000000, st.route};
                HWIO_OFS_IRQ_STATUS: next_st.rdata = {30'h00000000, st.status};
                HWIO_OFS_IRQ_ENABLE: next_st.rdata = {30'h00000000, st.ien};
                HWIO_OFS_XFER_CTRL: next_st.rdata = {24'h000000, st.wait_len};
                HWIO_OFS_STRAP_STAT: next_st.rdata = {26'h0000000, st.clk_seen, st.straps};
                default: next_st.rdata = '0;
            endcase
        end
        if (bus_acc)
            next_st.ack = 1'b1;
        next_st.irq = |(next_st.status & st.ien);
    end

    // every register returns to its default under reset
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            st <= '0;
            st.wait_len <= HWIO_WAIT_RESET;
            st.ctl <= HWIO_CTL_RESET;
            st.route <= HWIO_ROUTE_RESET;
        end
        else
            st <= next_st;
    end

    // primary pin: all sources, gated by its enable bit
    hwio_irq_out u_pri (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .req_i(any_irq),
        .en_i(st.ctl[HWIO_CTL_PRI_EN]),
        .pol_high_i(st.ctl[HWIO_CTL_PRI_POL]),
        .pin_o(PRIMARY_IRQ_OUT_O),
        .pin_oe_o(PRIMARY_IRQ_OUT_OE_O)
    );

    // secondary pin: all sources or one dedicated source
    hwio_irq_out u_sec (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .req_i(sec_req),
        .en_i(st.ctl[HWIO_CTL_SEC_EN]),
        .pol_high_i(st.ctl[HWIO_CTL_SEC_POL]),
        .pin_o(SECONDARY_IRQ_OUT_O),
        .pin_oe_o(SECONDARY_IRQ_OUT_OE_O)
    );

    // outputs come straight from flip-flops; all clear under reset except waitrequest, the inverted ack, which is high
    assign WAIT_PIN_O = st.wait_pin;
    assign WAIT_PIN_OE_O = st.wait_oe;
    assign XFER_DONE_O = st.done;
    assign BUS_CLOCK_SEEN_O = st.clk_seen;
    assign IRQ_O = st.irq;
    assign AVS_READDATA_O = st.rdata;
    assign AVS_WAITREQUEST_O = !st.ack;

    // named steps of the wait sequence
    sequence s_wait_active;
        WAIT_PIN_OE_O && WAIT_PIN_O == wait_high;
    endsequence
    sequence s_wait_inactive;
        WAIT_PIN_OE_O && WAIT_PIN_O == !wait_high;
    endsequence

    property p_wait_start;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st.wst == ST_IDLE && start_s && st.strap_taken |=> s_wait_active;
    endproperty
    a_wait_start: assert property (p_wait_start) else $error("wait not active");

    property p_wait_end;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        $rose(XFER_DONE_O) |-> s_wait_inactive;
    endproperty
    a_wait_end: assert property (p_wait_end) else $error("wait not inactive at done");

    property p_wait_release;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        XFER_DONE_O |-> s_wait_inactive ##1 !WAIT_PIN_OE_O;
    endproperty
    a_wait_release: assert property (p_wait_release) else $error("wait not released");

    property p_wait_pol;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st.wst == ST_WAIT |-> WAIT_PIN_O == wait_is_high(st.straps);
    endproperty
    a_wait_pol: assert property (p_wait_pol) else $error("wait polarity wrong");

    property p_reset_regs;
        @(posedge CLK_I) SYS_RST_I |=> st.ctl == HWIO_CTL_RESET && st.status == '0;
    endproperty
    a_reset_regs: assert property (p_reset_regs) else $error("register not reset");

    property p_reset_outs;
        @(posedge CLK_I) SYS_RST_I |=> !WAIT_PIN_OE_O && !PRIMARY_IRQ_OUT_OE_O
            && !SECONDARY_IRQ_OUT_OE_O && !IRQ_O;
    endproperty
    a_reset_outs: assert property (p_reset_outs) else $error("output active in reset");

    property p_pri_gate;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        !st.ctl[HWIO_CTL_PRI_EN] |=> !PRIMARY_IRQ_OUT_OE_O;
    endproperty
    a_pri_gate: assert property (p_pri_gate) else $error("primary driven while off");

    property p_pri_all;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st.ctl[HWIO_CTL_PRI_EN] && any_irq && $stable(st.ctl)
            |=> PRIMARY_IRQ_OUT_O == $past(st.ctl[HWIO_CTL_PRI_POL]);
    endproperty
    a_pri_all: assert property (p_pri_all) else $error("primary missed request");

    property p_sec_ded;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st.ctl[HWIO_CTL_SEC_EN] && st.route[HWIO_ROUTE_DED] && !src_s[st.route[3:0]]
            && $stable(st.ctl) |=> SECONDARY_IRQ_OUT_O == !$past(st.ctl[HWIO_CTL_SEC_POL]);
    endproperty
    a_sec_ded: assert property (p_sec_ded) else $error("secondary not dedicated");

    property p_sec_off;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        !st.ctl[HWIO_CTL_SEC_EN] |=> !SECONDARY_IRQ_OUT_OE_O;
    endproperty
    a_sec_off: assert property (p_sec_off) else $error("secondary driven while off");

    // pin levels follow the setting of the cycle before, since the outputs are registered
    property p_sec_all;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st.ctl[HWIO_CTL_SEC_EN] && !st.route[HWIO_ROUTE_DED] && any_irq
            |=> SECONDARY_IRQ_OUT_O == $past(st.ctl[HWIO_CTL_SEC_POL]);
    endproperty
    a_sec_all: assert property (p_sec_all) else $error("secondary missed all");

    property p_sec_hit;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st.ctl[HWIO_CTL_SEC_EN] && st.route[HWIO_ROUTE_DED] && src_s[st.route[3:0]]
            |=> SECONDARY_IRQ_OUT_O == $past(st.ctl[HWIO_CTL_SEC_POL]);
    endproperty
    a_sec_hit: assert property (p_sec_hit) else $error("secondary missed source");

    property p_pri_quiet;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        !st.ctl[HWIO_CTL_PRI_EN] |=> PRIMARY_IRQ_OUT_O == !$past(st.ctl[HWIO_CTL_PRI_POL]);
    endproperty
    a_pri_quiet: assert property (p_pri_quiet) else $error("primary active off");

    property p_sec_quiet;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        !st.ctl[HWIO_CTL_SEC_EN] |=> SECONDARY_IRQ_OUT_O == !$past(st.ctl[HWIO_CTL_SEC_POL]);
    endproperty
    a_sec_quiet: assert property (p_sec_quiet) else $error("secondary active off");

    property p_wait_idle;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st.wst == ST_IDLE && !(start_s && st.strap_taken) |=> !WAIT_PIN_OE_O;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("wait driven in idle");

    property p_wait_hold;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st.wst == ST_WAIT && st.cnt > 8'h01 |=> s_wait_active;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait dropped early");

    property p_pri_driven;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st.ctl[HWIO_CTL_PRI_EN] |=> PRIMARY_IRQ_OUT_OE_O;
    endproperty
    a_pri_driven: assert property (p_pri_driven) else $error("primary not driven");
endmodule

// ==== design/hwio_pkg.sv ====
// shared constants for the host wait and interrupt output block
package hwio_pkg;
    // avalon register byte offsets
    localparam logic [7:0] HWIO_OFS_IRQ_OUT_CTRL = 8'h2A;
    localparam logic [7:0] HWIO_OFS_IRQ_ROUTE = 8'h22;
    localparam logic [7:0] HWIO_OFS_IRQ_STATUS = 8'h00;
    localparam logic [7:0] HWIO_OFS_IRQ_ENABLE = 8'h04;
    localparam logic [7:0] HWIO_OFS_IRQ_CLEAR = 8'h08;
    localparam logic [7:0] HWIO_OFS_XFER_CTRL = 8'h0C;
    localparam logic [7:0] HWIO_OFS_STRAP_STAT = 8'h10;
    // interrupt output control field positions
    localparam int HWIO_CTL_PRI_EN = 15;
    localparam int HWIO_CTL_PRI_POL = 14;
    localparam int HWIO_CTL_SEC_EN = 13;
    localparam int HWIO_CTL_SEC_POL = 12;
    localparam logic [15:0] HWIO_CTL_RESET = 16'h0000;
    // routing register: bit 4 selects dedicated mode, bits 3:0 the source
    localparam int HWIO_ROUTE_DED = 4;
    localparam logic [4:0] HWIO_ROUTE_RESET = 5'h00;
    // event bits of the block's own status register
    localparam int HWIO_EV_XFER_DONE = 0;
    localparam int HWIO_EV_IRQ_EDGE = 1;
    localparam int HWIO_EV_W = 2;
    // strap code whose wait output is active high; others active low
    localparam logic [4:0] HWIO_STRAP_WAIT_HIGH = 5'h04;
    localparam int HWIO_NUM_SRC = 16;
    // transfer latency in cycles while the wait output is active
    localparam logic [7:0] HWIO_WAIT_RESET = 8'h04;
    // wait output is driven inactive this long before it is released
    localparam int HWIO_RELEASE_NS = 8;
    localparam int HWIO_CLK_NS = 8;
    localparam int HWIO_RELEASE_CYC =
        (HWIO_RELEASE_NS + HWIO_CLK_NS - 1) / HWIO_CLK_NS;
endpackage

// ==== design/hwio_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module hwio_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } hwio_sync_type;
    hwio_sync_type st;
    hwio_sync_type next_st;
    // first stage feeds only the second stage
    always_comb
    begin
        next_st.meta = d_i;
        next_st.sync = st.meta;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st <= '0;
        else
            st <= next_st;
    end
    assign q_o = st.sync;
endmodule

// ==== design/hwio_irq_out.sv ====
// one interrupt output pin: enable, polarity and tri-state control
`timescale 1ns/10ps
module hwio_irq_out (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic en_i,
    input wire logic pol_high_i,
    output logic pin_o,
    output logic pin_oe_o
);
    typedef struct packed {
        logic pin;
        logic oe;
    } hwio_irq_type;
    hwio_irq_type st;
    hwio_irq_type next_st;
    // a disabled output floats and never shows a request
    always_comb
    begin
        next_st.oe = en_i;
        next_st.pin = (en_i && req_i) ? pol_high_i : !pol_high_i;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st <= '0;
        else
            st <= next_st;
    end
    assign pin_o = st.pin;
    assign pin_oe_o = st.oe;
endmodule

// ==== verification/hwio_host_model.sv ====
// host bus master model: raises transfer requests and runs the bus clock
`timescale 1ns/10ps
module hwio_host_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic wait_oe_i,
    output logic start_o,
    output logic bus_clk_o
);
    // request held until the device drives its wait pin, so no transfer is lost
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            start_o <= 1'b0;
        else if (wait_oe_i)
            start_o <= 1'b0;
        else if (go_i)
            start_o <= 1'b1;
    end
    // bus clock only runs while a transfer is pending, still between them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            bus_clk_o <= 1'b0;
        else if (start_o)
            bus_clk_o <= !bus_clk_o;
    end
endmodule

// ==== verification/hwio_top_bench.sv ====
// self-checking bench for the host wait and interrupt output block
`timescale 1ns/10ps
module hwio_top_bench;
    import hwio_pkg::*;
    logic CLK_I = 0;
    logic SYS_RST_I = 1;
    logic [7:0] AVS_ADDRESS_I = 8'h00;
    logic AVS_READ_I = 0;
    logic AVS_WRITE_I = 0;
    logic [31:0] AVS_WRITEDATA_I = 32'h0;
    logic [31:0] AVS_READDATA_O;
    logic AVS_WAITREQUEST_O;
    logic XFER_START_I;
    logic [4:0] HOST_SELECT_STRAPS_I = 5'h04;
    logic HOST_BUS_CLOCK_I;
    logic [15:0] IRQ_SRC_I = 16'h0;
    logic WAIT_PIN_O, WAIT_PIN_OE_O, XFER_DONE_O, BUS_CLOCK_SEEN_O;
    logic PRIMARY_IRQ_OUT_O, PRIMARY_IRQ_OUT_OE_O, SECONDARY_IRQ_OUT_O;
    logic SECONDARY_IRQ_OUT_OE_O, IRQ_O;
    logic go = 0;
    logic [31:0] q;
    int error_cnt = 0;
    int total_checks = 0;
    hwio_top hwio_top_i (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
        .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
        .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
        .XFER_START_I(XFER_START_I), .HOST_SELECT_STRAPS_I(HOST_SELECT_STRAPS_I),
        .HOST_BUS_CLOCK_I(HOST_BUS_CLOCK_I), .IRQ_SRC_I(IRQ_SRC_I), .WAIT_PIN_O(WAIT_PIN_O),
        .WAIT_PIN_OE_O(WAIT_PIN_OE_O), .XFER_DONE_O(XFER_DONE_O),
        .BUS_CLOCK_SEEN_O(BUS_CLOCK_SEEN_O), .PRIMARY_IRQ_OUT_O(PRIMARY_IRQ_OUT_O),
        .PRIMARY_IRQ_OUT_OE_O(PRIMARY_IRQ_OUT_OE_O), .SECONDARY_IRQ_OUT_O(SECONDARY_IRQ_OUT_O),
        .SECONDARY_IRQ_OUT_OE_O(SECONDARY_IRQ_OUT_OE_O), .IRQ_O(IRQ_O));
    hwio_host_model hwio_host_model_i (.clk_i(CLK_I), .rst_i(SYS_RST_I), .go_i(go),
        .wait_oe_i(WAIT_PIN_OE_O), .start_o(XFER_START_I), .bus_clk_o(HOST_BUS_CLOCK_I));
    // 125 MHz clock
    always #4 CLK_I = !CLK_I;
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon access; request held until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK_I);
        AVS_ADDRESS_I <= a;
        AVS_WRITEDATA_I <= d;
        AVS_WRITE_I <= wr;
        AVS_READ_I <= !wr;
        do
        begin
            @(posedge CLK_I);
            n++;
        end while (AVS_WAITREQUEST_O !== 1'b0 && n < 20);
        if (n >= 20)
            check(32'h1, 32'h0);
        q = AVS_READDATA_O;
        AVS_READ_I <= 1'b0;
        AVS_WRITE_I <= 1'b0;
    endtask
    // reset with a given strap code, then check outputs and defaults
    task t_reset(input logic [4:0] straps);
        @(posedge CLK_I);
        HOST_SELECT_STRAPS_I <= straps;
        SYS_RST_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        SYS_RST_I <= 1'b0;
        check({WAIT_PIN_OE_O, PRIMARY_IRQ_OUT_OE_O, SECONDARY_IRQ_OUT_OE_O, IRQ_O}, 0);
        check(AVS_WAITREQUEST_O, 1'b1);
        repeat (2) @(posedge CLK_I);
        bus(0, HWIO_OFS_IRQ_OUT_CTRL, 0);
        check(q, 32'(HWIO_CTL_RESET));
        bus(0, HWIO_OFS_IRQ_ROUTE, 0);
        check(q, 32'(HWIO_ROUTE_RESET));
        bus(0, HWIO_OFS_XFER_CTRL, 0);
        check(q, 32'(HWIO_WAIT_RESET));
        $display("test reset done");
    endtask
    // one host transfer of len cycles with the expected active wait level
    task t_wait(input logic act, input logic [7:0] len);
        int n;
        bus(1, HWIO_OFS_XFER_CTRL, {24'h0, len});
        @(posedge CLK_I);
        go <= 1'b1;
        n = 0;
        while (WAIT_PIN_OE_O !== 1'b1 && n < 50)
        begin
            @(posedge CLK_I);
            n++;
        end
        go <= 1'b0;
        check(WAIT_PIN_O, act);
        n = 0;
        while (XFER_DONE_O !== 1'b1 && n < 50)
        begin
            check(WAIT_PIN_O, act);
            @(posedge CLK_I);
            n++;
        end
        check(32'(n), {24'h0, len});
        check({WAIT_PIN_OE_O, WAIT_PIN_O}, {1'b1, !act});
        @(posedge CLK_I);
        check(WAIT_PIN_OE_O, 1'b0);
        repeat (6) @(posedge CLK_I);
        check(BUS_CLOCK_SEEN_O, 1'b1);
        $display("test wait done");
    endtask
    // sets sources and waits out the synchroniser and output register
    task src(input logic [15:0] s);
        IRQ_SRC_I <= s;
        repeat (5) @(posedge CLK_I);
    endtask
    task t_pins;
        src(16'h0020);
        check({PRIMARY_IRQ_OUT_OE_O, SECONDARY_IRQ_OUT_OE_O}, 0);
        bus(1, HWIO_OFS_IRQ_OUT_CTRL, 32'h0000F000);
        src(16'h0020);
        check({PRIMARY_IRQ_OUT_OE_O, PRIMARY_IRQ_OUT_O}, 2'b11);
        check({SECONDARY_IRQ_OUT_OE_O, SECONDARY_IRQ_OUT_O}, 2'b11);
        bus(1, HWIO_OFS_IRQ_ROUTE, 32'h13);
        src(16'h0020);
        check(SECONDARY_IRQ_OUT_O, 1'b0);
        src(16'h0008);
        check({SECONDARY_IRQ_OUT_O, PRIMARY_IRQ_OUT_O}, 2'b11);
        bus(1, HWIO_OFS_IRQ_OUT_CTRL, 32'h0000A000);
        src(16'h0008);
        check({PRIMARY_IRQ_OUT_OE_O, PRIMARY_IRQ_OUT_O}, 2'b10);
        bus(1, HWIO_OFS_IRQ_OUT_CTRL, 32'h00002000);
        src(16'h0008);
        check(PRIMARY_IRQ_OUT_OE_O, 1'b0);
        $display("test pins done");
    endtask
    // sticky status, enable mask, clear and an unmapped address
    task t_status;
        src(16'h0000);
        src(16'h0100);
        check(IRQ_O, 1'b0);
        bus(0, HWIO_OFS_IRQ_STATUS, 0);
        check(q[HWIO_EV_IRQ_EDGE], 1'b1);
        check(q[HWIO_EV_XFER_DONE], 1'b1);
        bus(1, HWIO_OFS_IRQ_ENABLE, 32'h2);
        repeat (2) @(posedge CLK_I);
        check(IRQ_O, 1'b1);
        bus(1, HWIO_OFS_IRQ_CLEAR, 32'h2);
        repeat (2) @(posedge CLK_I);
        check(IRQ_O, 1'b0);
        bus(0, 8'h40, 0);
        check(q, 32'h0);
        $display("test status done");
    endtask
    initial
    begin
        t_reset(HWIO_STRAP_WAIT_HIGH);
        t_wait(1'b1, 8'h04);
        bus(0, HWIO_OFS_STRAP_STAT, 0);
        check(q, {26'h0, 1'b1, HWIO_STRAP_WAIT_HIGH});
        t_pins();
        t_status();
        bus(1, HWIO_OFS_IRQ_OUT_CTRL, 32'h0000F000);
        t_reset(5'h1F);
        t_wait(1'b0, 8'h06);
        stop_test();
    end
    // watchdog far beyond the roughly 150 cycles the tests need
    initial
    begin
        #200000;
        error_cnt++;
        stop_test();
    end
endmodule
